// ==== nested_priority_interrupt_ctrl_tb.sv ====
`timescale 1ns/1ps
`include "npic_regs.svh"
module nested_priority_interrupt_ctrl_tb;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic        halt_req = 1'b0;
   logic        wt = 1'b0;
   logic [2:0]  k_reg = 3'h0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [7:0]  cc_data = 8'h0;
   // Pins idle high, as with pull-ups
   logic [23:0] pins = 24'hFFFFFF;
   logic [12:0] flag = 13'h0;
   logic [12:0] en = 13'h0;
   logic [12:0] clr = 13'h0;
   logic [31:0] rd, hrdata;
   logic [7:0]  cc_int, stk_d;
   logic [15:0] vec;
   logic [39:0] stk;
   logic        hrdy, hresp, iend, busy, stk_we, pc_ld, wake, halt;
   int          errors = 0;
   int          checked = 0;

   always #25 clk = !clk;

   npic_top i_npic_top (
      .sys_clk_i(clk), .rst_b_i(rst_b), .ce_i(1'b1), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hready_i(hrdy),
      .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
      .instr_end_i(iend), .trap_i(k_reg[2]), .return_from_interrupt_i(k_reg[1]), .cc_wr_i(k_reg[0]),
      .cc_data_i(cc_data), .cc_i(cc_int), .pc_i(16'h1234), .x_i(8'h56), .a_i(8'h78),
      .halt_i(halt), .wait_i(wt), .busy_o(busy), .stk_we_o(stk_we),
      .stk_data_o(stk_d), .pc_load_o(pc_ld), .vector_o(vec), .cc_int_o(cc_int),
      .wake_o(wake), .ext_pins_i(pins), .periph_flag_i(flag), .periph_en_i(en),
      .periph_clr_i(clr));

   npic_core_model i_npic_core_model (
      .sys_clk_i(clk), .rst_b_i(rst_b), .busy_i(busy), .stk_we_i(stk_we),
      .stk_data_i(stk_d), .wake_i(wake), .halt_req_i(halt_req), .instr_end_o(iend),
      .halt_o(halt), .stk_o(stk));

   function automatic logic [7:0] ccv(input logic [1:0] l);
      return {2'b11, l[1], 1'b0, l[0], 3'b010};
   endfunction : ccv

   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge clk); while (hrdy !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hrdy !== 1'b1);
      rd = hrdata;
   endtask : ahb

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0);
      chk(rd, e);
      chk(hresp, 1'b0);
   endtask : rchk

   // Bits are trap, return, cc write
   task automatic pulse(input logic [2:0] k, input logic [1:0] l);
      @(posedge clk);
      cc_data <= ccv(l);
      k_reg <= k;
      @(posedge clk);
      k_reg <= 3'h0;
   endtask : pulse

   task automatic entry(input logic [15:0] v, input logic [1:0] l, input logic [1:0] o,
                        input logic s);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (pc_ld !== 1'b1 && n < 200);
      chk(pc_ld, 1'b1);
      chk(vec, v);
      chk(cc_int, ccv(l));
      if (s) chk(stk, {8'h34, 8'h12, 8'h56, 8'h78, ccv(o)});
      // Back on a rising edge so later drives stay edge-aligned
      @(posedge clk);
   endtask : entry

   task automatic clear(input logic [12:0] f, input logic [12:0] c);
      flag <= f;
      clr <= c;
      @(posedge clk);
      clr <= 13'h0;
   endtask : clear

   task results;
      $display("Checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : results

   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      results();
   end

   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      entry(`NPIC_VEC_RESET, 2'b11, 2'b00, 1'b0);
      rchk(`NPIC_OFS_PRI0, 32'hFF);
      rchk(8'h40, 32'h0);
      ahb(1'b1, `NPIC_OFS_PRI0, 32'hCF);
      ahb(1'b1, `NPIC_OFS_PRI0, 32'h64);
      rchk(`NPIC_OFS_PRI0, 32'h44);
      ahb(1'b1, `NPIC_OFS_PRI1, 32'hC7);
      ahb(1'b1, `NPIC_OFS_PRI2, 32'hDF);
      flag <= 13'h0060;
      en <= 13'h0040;
      rchk(`NPIC_OFS_STAT, 32'h00030040);
      en <= 13'h0060;
      pulse(3'b001, `NPIC_LVL0);
      entry(16'hFFEE, `NPIC_LVL2, `NPIC_LVL0, 1'b1);
      clear(13'h0020, 13'h0040);
      rchk(`NPIC_OFS_STAT, 32'h00000020);
      pulse(3'b010, `NPIC_LVL0);
      entry(16'hFFF0, `NPIC_LVL1, `NPIC_LVL0, 1'b1);
      clear(13'h0000, 13'h0020);
      pulse(3'b001, `NPIC_LVL3);
      pulse(3'b100, `NPIC_LVL3);
      entry(`NPIC_VEC_TRAP, `NPIC_LVL3, `NPIC_LVL3, 1'b1);
      ahb(1'b1, `NPIC_OFS_SENS, 32'h1);
      pins <= 24'hFFFF00;
      repeat (6) @(posedge clk);
      pulse(3'b001, `NPIC_LVL0);
      pins <= 24'hFFFF02;
      entry(16'hFFF6, `NPIC_LVL2, `NPIC_LVL0, 1'b1);
      rchk(`NPIC_OFS_STAT, 32'h0);
      pulse(3'b010, `NPIC_LVL0);
      @(posedge clk);
      halt_req <= 1'b1;
      @(posedge clk);
      halt_req <= 1'b0;
      flag <= 13'h0002;
      en <= 13'h0402;
      repeat (12) @(posedge clk);
      chk(wake, 1'b0);
      flag <= 13'h0402;
      entry(16'hFFE6, `NPIC_LVL1, `NPIC_LVL0, 1'b1);
      pulse(3'b010, `NPIC_LVL0);
      entry(16'hFFF8, `NPIC_LVL1, `NPIC_LVL0, 1'b1);
      wt <= 1'b1;
      repeat (2) @(posedge clk);
      chk(wake, 1'b1);
      results();
   end
endmodule : nested_priority_interrupt_ctrl_tb

// ==== npic_arb.sv ====
`timescale 1ns/1ps
`include "npic_regs.svh"
module npic_arb #(
   parameter int N = 13
) (
   npic_arb_if.arb a
);
   if (N < 1 || N > 16) begin : g_bad_n
      $error("npic_arb: N must be 1 to 16");
   end

   // RQ7 two-step selection
   always_comb begin
      logic [1:0] r;
      logic [1:0] best;
      r          = 2'h0;
      best       = 2'h0;
      a.valid    = 1'b0;
      a.idx      = 4'h0;
      a.pri_code = `NPIC_LVL3;
      for (int i = N - 1; i >= 0; i--) begin
         r = npic_pkg::npic_rank(a.pri[2*i +: 2]);
         // RQ13 strictly above current level
         if (a.cand[i] && r > a.cur_rank && (!a.valid || r >= best)) begin
            a.valid    = 1'b1;
            a.idx      = 4'(i);
            a.pri_code = a.pri[2*i +: 2];
            best       = r;
         end
      end
   end
endmodule : npic_arb

// ==== npic_arb_if.sv ====
`timescale 1ns/1ps
interface npic_arb_if #(parameter int N = 13);
   logic [N-1:0]   cand;
   logic [2*N-1:0] pri;
   logic [1:0]     cur_rank;
   logic           valid;
   logic [3:0]     idx;
   logic [1:0]     pri_code;
   modport arb (input cand, pri, cur_rank, output valid, idx, pri_code);
   modport ctl (output cand, pri, cur_rank, input valid, idx, pri_code);
endinterface : npic_arb_if

// ==== npic_core_model.sv ====
`timescale 1ns/1ps
module npic_core_model (
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_b_i,
   // From controller; halt_req_i from the testbench
   input  wire logic        busy_i,
   input  wire logic        stk_we_i,
   input  wire logic [7:0]  stk_data_i,
   input  wire logic        wake_i,
   input  wire logic        halt_req_i,
   // To controller; stk_o to the testbench
   output logic             instr_end_o,
   output logic             halt_o,
   output logic [39:0]      stk_o
);
   logic tog_reg;
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) tog_reg <= 1'b0;
      else tog_reg <= !tog_reg;
   end
   assign instr_end_o = tog_reg && !busy_i && !halt_o;
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) stk_o <= 40'h0;
      else if (stk_we_i) stk_o <= {stk_o[31:0], stk_data_i};
   end
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) halt_o <= 1'b0;
      else if (halt_req_i) halt_o <= 1'b1;
      else if (wake_i) halt_o <= 1'b0;
   end
endmodule : npic_core_model

// ==== npic_ext_line.sv ====
`timescale 1ns/1ps
`include "npic_regs.svh"
module npic_ext_line #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         sys_clk_i,
   input  wire logic         rst_b_i,
   input  wire logic         ce_i,
   // Pins and control
   input  wire logic [W-1:0] pins_i,
   input  wire logic [W-1:0] sel_i,
   input  wire logic [1:0]   sens_i,
   input  wire logic         ack_i,
   // Request
   output logic              req_o
);
   logic [W-1:0] s1_reg, s2_reg, s3_reg, pin_reg;
   logic         line_reg, lat_reg, line;
   logic         rise, fall, edge_hit;

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s1_reg  <= '1;
         s2_reg  <= '1;
         s3_reg  <= '1;
         pin_reg <= '1;
      end else if (ce_i) begin
         s1_reg <= pins_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         for (int i = 0; i < W; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
               pin_reg[i] <= s3_reg[i];
            end
         end
      end
   end

   // RQ16 selected pins ORed
   assign line = |(pin_reg & sel_i);
   assign rise = line && !line_reg;
   assign fall = !line && line_reg;

   always_comb begin
      case (sens_i)
         `NPIC_SENS_RISE: edge_hit = rise;
         `NPIC_SENS_FALL: edge_hit = fall;
         `NPIC_SENS_LOWF: edge_hit = fall;
         default:         edge_hit = rise || fall;
      endcase
   end

   // RQ15 edge latch, new edge wins over entry clear
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         // Matches the all-ones pin reset so no false edge follows reset
         line_reg <= 1'b1;
         lat_reg  <= 1'b0;
      end else if (ce_i) begin
         line_reg <= line;
         lat_reg  <= edge_hit || (lat_reg && !ack_i);
      end
   end

   // RQ14 low level keeps requesting in mode 00
   assign req_o = lat_reg || (sens_i == `NPIC_SENS_LOWF && !line && |sel_i);
endmodule : npic_ext_line

// ==== npic_pkg.sv ====
`include "npic_regs.svh"
package npic_pkg;
   typedef enum logic [1:0] {
      ST_RESET = 2'b00,
      ST_IDLE  = 2'b01,
      ST_PUSH  = 2'b10,
      ST_VEC   = 2'b11
   } npic_state_e;

   // RQ6 rank of level codes
   function automatic logic [1:0] npic_rank(input logic [1:0] code);
      case (code)
         `NPIC_LVL0: return 2'h0;
         `NPIC_LVL1: return 2'h1;
         `NPIC_LVL2: return 2'h2;
         default:    return 2'h3;
      endcase
   endfunction : npic_rank

   // Field-wise write that refuses level 0
   function automatic logic [7:0] npic_pri_wr(input logic [7:0] old_v, input logic [7:0] new_v);
      logic [7:0] res;
      res = old_v;
      for (int f = 0; f < 4; f++) begin
         if (new_v[2*f +: 2] != `NPIC_LVL0) begin
            res[2*f +: 2] = new_v[2*f +: 2];
         end
      end
      return res;
   endfunction : npic_pri_wr
endpackage : npic_pkg

// ==== npic_regs.svh ====
`ifndef NPIC_REGS_SVH
`define NPIC_REGS_SVH
// Summary of operation
// RQ1 - Entry starts only at the end of the current instruction.
// RQ2 - Entry pushes PC, X, A and CC onto the stack.
// RQ3 - Entry loads the CC priority bits with the vector's software priority.
// RQ4 - After stacking, PC is loaded with the serviced vector address.
// RQ5 - Return from interrupt restores the popped priority bits.
// RQ6 - Priority codes: level 0 is 10, 1 is 01, 2 is 00, 3 is 11.
// RQ7 - Highest software priority wins; ties go to the lowest vector number.
// RQ8 - Requests not served stay latched until they win arbitration.
// RQ9 - Reset and trap ignore the current level and enter at level 3.
// RQ10 - Reset and trap can end Halt.
// RQ11 - The trap instruction raises a trap entry through the normal sequence.
// RQ12 - Reset has top priority and starts at level 3.
// RQ13 - Maskable requests need enable and a level strictly above the current one.
// RQ14 - External lines wake from Halt; sensitivity set by a software register.
// RQ15 - Edge-triggered external requests are latched and cleared on entry.
// RQ16 - Selected pins of one group are ORed into their line.
// RQ17 - Peripheral requests need both the status flag and its enable.
// RQ18 - The peripheral clear sequence drops the latched request.
// RQ19 - Any source ends Wait; only Halt-capable sources end Halt.
// RQ20 - First service after Halt is a Halt-capable source.
// RQ21 - Priority bits sit at CC bits 5 and 3 and reset to 11.
// RQ22 - Priority-changing instructions can write the priority bits.
// RQ23 - Writing level 0 to a vector priority field keeps the old value.
`define NPIC_OFS_PRI0  8'h00
`define NPIC_OFS_PRI1  8'h04
`define NPIC_OFS_PRI2  8'h08
`define NPIC_OFS_PRI3  8'h0C
`define NPIC_OFS_SENS  8'h10
`define NPIC_OFS_PSEL  8'h14
`define NPIC_OFS_STAT  8'h18
`define NPIC_PRI_RST   8'hFF
`define NPIC_PRI3_RO   8'hF0
`define NPIC_PSEL_RST  32'hFFFFFFFF
`define NPIC_LVL0      2'b10
`define NPIC_LVL1      2'b01
`define NPIC_LVL2      2'b00
`define NPIC_LVL3      2'b11
`define NPIC_SENS_LOWF 2'b00
`define NPIC_SENS_RISE 2'b01
`define NPIC_SENS_FALL 2'b10
`define NPIC_CC_HI     5
`define NPIC_CC_LO     3
`define NPIC_CC_RST    8'hEA
`define NPIC_VEC_RESET 16'hFFFE
`define NPIC_VEC_TRAP  16'hFFFC
`define NPIC_VEC_BASE  16'hFFFA
`define NPIC_HALT_CAP  13'h041D
`define NPIC_EXT_V0    2
`define NPIC_PUSH_N    3'h5
`endif

// ==== npic_top.sv ====
`timescale 1ns/1ps
`include "npic_regs.svh"
module npic_top #(
   parameter int          EXT_W    = 8,
   parameter logic [12:0] HALT_CAP = `NPIC_HALT_CAP
) (
   // Clock, reset, enable
   input  wire logic               sys_clk_i,
   input  wire logic               rst_b_i,
   input  wire logic               ce_i,
   // AHB-Lite slave
   input  wire logic               hsel_i,
   input  wire logic [31:0]        haddr_i,
   input  wire logic [1:0]         htrans_i,
   input  wire logic               hwrite_i,
   input  wire logic [2:0]         hsize_i,
   input  wire logic               hready_i,
   input  wire logic [31:0]        hwdata_i,
   output logic [31:0]             hrdata_o,
   output logic                    hreadyout_o,
   output logic                    hresp_o,
   // Core side
   input  wire logic               instr_end_i,
   input  wire logic               trap_i,
   input  wire logic               return_from_interrupt_i,
   input  wire logic               cc_wr_i,
   input  wire logic [7:0]         cc_data_i,
   input  wire logic [7:0]         cc_i,
   input  wire logic [15:0]        pc_i,
   input  wire logic [7:0]         x_i,
   input  wire logic [7:0]         a_i,
   input  wire logic               halt_i,
   input  wire logic               wait_i,
   output logic                    busy_o,
   output logic                    stk_we_o,
   output logic [7:0]              stk_data_o,
   output logic                    pc_load_o,
   output logic [15:0]             vector_o,
   output logic [7:0]              cc_int_o,
   output logic                    wake_o,
   // Interrupt sources
   input  wire logic [3*EXT_W-1:0] ext_pins_i,
   input  wire logic [12:0]        periph_flag_i,
   input  wire logic [12:0]        periph_en_i,
   input  wire logic [12:0]        periph_clr_i
);
   localparam int PW = 3 * EXT_W;

   if (EXT_W < 1 || EXT_W > 10) begin : g_bad_w
      $error("npic_top: EXT_W must be 1 to 10");
   end

   npic_pkg::npic_state_e state_reg;
   logic [2:0]    cnt_reg;
   logic [39:0]   shr_reg;
   logic [1:0]    cc_pri_reg;
   logic [7:0]    pri_reg [4];
   logic [5:0]    sens_reg;
   logic [PW-1:0] psel_reg;
   logic [12:0]   pend_reg, pend, src, cand;
   logic [2:0]    ext_req, ext_ack;
   logic          trap_pend_reg, halt_exit_reg, wake_reg;
   logic          svc_trap_reg;
   logic [3:0]    svc_idx_reg;
   logic [1:0]    svc_code_reg;
   logic          stk_we_reg, pc_load_reg;
   logic [7:0]    stk_data_reg;
   logic [15:0]   vector_reg;
   logic          take, take_trap, push_end;
   logic [7:0]    cc_img;
   logic          acc, wr_ph_reg;
   logic [7:0]    wa_reg;
   logic [31:0]   rd_word, hrdata_reg;

   npic_arb_if #(.N(13)) arb_if ();

   npic_arb #(.N(13)) u_arb (
      .a (arb_if)
   );

   // External lines
   for (genvar g = 0; g < 3; g++) begin : g_ext
      npic_ext_line #(.W(EXT_W)) u_line (
         .sys_clk_i (sys_clk_i),
         .rst_b_i   (rst_b_i),
         .ce_i      (ce_i),
         .pins_i    (ext_pins_i[g*EXT_W +: EXT_W]),
         .sel_i     (psel_reg[g*EXT_W +: EXT_W]),
         .sens_i    (sens_reg[2*g +: 2]),
         .ack_i     (ext_ack[g]),
         .req_o     (ext_req[g])
      );
      // RQ15 auto clear on entry
      assign ext_ack[g] = take && !trap_pend_reg && arb_if.idx == 4'(`NPIC_EXT_V0 + g);
   end

   // RQ17 flag and enable
   always_comb begin
      src = periph_flag_i & periph_en_i;
      src[`NPIC_EXT_V0 +: 3] = 3'h0;
      pend = pend_reg;
      pend[`NPIC_EXT_V0 +: 3] = ext_req;
   end

   // RQ8 latched until served; RQ18 clear sequence drops it
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pend_reg <= 13'h0000;
      end else if (ce_i) begin
         pend_reg <= (pend_reg | src) & ~periph_clr_i;
      end
   end

   // RQ20 Halt-capable sources first after Halt
   assign cand            = (halt_i || halt_exit_reg) ? (pend & HALT_CAP) : pend;
   assign arb_if.cand     = cand;
   assign arb_if.pri      = {pri_reg[3][1:0], pri_reg[2], pri_reg[1], pri_reg[0]};
   assign arb_if.cur_rank = npic_pkg::npic_rank(cc_pri_reg);

   // RQ1 entry only at instruction end; RQ9 trap ignores level
   assign take      = state_reg == npic_pkg::ST_IDLE && instr_end_i
                      && (trap_pend_reg || arb_if.valid);
   assign take_trap = take && trap_pend_reg;
   assign push_end  = state_reg == npic_pkg::ST_PUSH && cnt_reg == `NPIC_PUSH_N;

   always_comb begin
      cc_img = cc_i;
      cc_img[`NPIC_CC_HI] = cc_pri_reg[1];
      cc_img[`NPIC_CC_LO] = cc_pri_reg[0];
   end

   // RQ11 trap raised; RQ10 and RQ19 wake
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         trap_pend_reg <= 1'b0;
         halt_exit_reg <= 1'b0;
         wake_reg      <= 1'b0;
      end else if (ce_i) begin
         trap_pend_reg <= trap_i || (trap_pend_reg && !take_trap);
         halt_exit_reg <= halt_i || (halt_exit_reg && !take);
         if (halt_i) begin
            wake_reg <= (|(pend & HALT_CAP)) || trap_pend_reg;
         end else begin
            wake_reg <= wait_i && ((|pend) || trap_pend_reg);
         end
      end
   end

   // Entry sequencer
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_reg    <= npic_pkg::ST_RESET;
         cnt_reg      <= 3'h0;
         shr_reg      <= 40'h0000000000;
         svc_trap_reg <= 1'b0;
         svc_idx_reg  <= 4'h0;
         svc_code_reg <= `NPIC_LVL3;
         stk_we_reg   <= 1'b0;
         stk_data_reg <= 8'h00;
         pc_load_reg  <= 1'b0;
         vector_reg   <= 16'h0000;
      end else if (ce_i) begin
         pc_load_reg <= 1'b0;
         case (state_reg)
            npic_pkg::ST_RESET: begin
               // RQ12 reset vector first, no stacking
               pc_load_reg <= 1'b1;
               vector_reg  <= `NPIC_VEC_RESET;
               state_reg   <= npic_pkg::ST_VEC;
            end
            npic_pkg::ST_IDLE: begin
               if (take) begin
                  svc_trap_reg <= trap_pend_reg;
                  svc_idx_reg  <= arb_if.idx;
                  svc_code_reg <= trap_pend_reg ? `NPIC_LVL3 : arb_if.pri_code;
                  // RQ2 stack image PCL, PCH, X, A, CC
                  shr_reg      <= {cc_img, a_i, x_i, pc_i[15:8], pc_i[7:0]};
                  cnt_reg      <= 3'h0;
                  state_reg    <= npic_pkg::ST_PUSH;
               end
            end
            npic_pkg::ST_PUSH: begin
               if (push_end) begin
                  stk_we_reg  <= 1'b0;
                  pc_load_reg <= 1'b1;
                  // RQ4 vector after stacking
                  vector_reg  <= svc_trap_reg ? `NPIC_VEC_TRAP
                                 : 16'(`NPIC_VEC_BASE - {11'h000, svc_idx_reg, 1'b0});
                  state_reg   <= npic_pkg::ST_VEC;
               end else begin
                  stk_we_reg   <= 1'b1;
                  stk_data_reg <= shr_reg[7:0];
                  shr_reg      <= {8'h00, shr_reg[39:8]};
                  cnt_reg      <= cnt_reg + 3'h1;
               end
            end
            default: begin
               state_reg <= npic_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // RQ21 priority bits reset to level 3
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cc_pri_reg <= `NPIC_LVL3;
      end else if (ce_i) begin
         if (push_end) begin
            // RQ3 load level of the serviced vector
            cc_pri_reg <= svc_code_reg;
         end else if (return_from_interrupt_i || cc_wr_i) begin
            // RQ5 and RQ22 popped or written priority bits
            cc_pri_reg <= {cc_data_i[`NPIC_CC_HI], cc_data_i[`NPIC_CC_LO]};
         end
      end
   end

   always_comb begin
      cc_int_o = `NPIC_CC_RST;
      cc_int_o[`NPIC_CC_HI] = cc_pri_reg[1];
      cc_int_o[`NPIC_CC_LO] = cc_pri_reg[0];
   end

   assign busy_o     = state_reg != npic_pkg::ST_IDLE;
   assign stk_we_o   = stk_we_reg;
   assign stk_data_o = stk_data_reg;
   assign pc_load_o  = pc_load_reg;
   assign vector_o   = vector_reg;
   assign wake_o     = wake_reg;

   // AHB-Lite slave, zero wait states while ce_i is high
   assign acc         = hsel_i && hready_i && htrans_i[1] && haddr_i[31:8] == 24'h000000;
   assign hreadyout_o = ce_i;
   assign hresp_o     = 1'b0;
   assign hrdata_o    = hrdata_reg;

   always_comb begin
      if (haddr_i[7:0] == `NPIC_OFS_PRI0) begin
         rd_word = {24'h000000, pri_reg[0]};
      end else if (haddr_i[7:0] == `NPIC_OFS_PRI1) begin
         rd_word = {24'h000000, pri_reg[1]};
      end else if (haddr_i[7:0] == `NPIC_OFS_PRI2) begin
         rd_word = {24'h000000, pri_reg[2]};
      end else if (haddr_i[7:0] == `NPIC_OFS_PRI3) begin
         rd_word = {24'h000000, pri_reg[3]};
      end else if (haddr_i[7:0] == `NPIC_OFS_SENS) begin
         rd_word = {26'h0000000, sens_reg};
      end else if (haddr_i[7:0] == `NPIC_OFS_PSEL) begin
         rd_word = 32'(psel_reg);
      end else if (haddr_i[7:0] == `NPIC_OFS_STAT) begin
         rd_word = {14'h0000, cc_pri_reg, 2'h0, trap_pend_reg, pend};
      end else begin
         rd_word = 32'h00000000;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_ph_reg  <= 1'b0;
         wa_reg     <= 8'h00;
         hrdata_reg <= 32'h00000000;
      end else if (ce_i) begin
         wr_ph_reg  <= acc && hwrite_i;
         hrdata_reg <= (acc && !hwrite_i) ? rd_word : 32'h00000000;
         if (acc) begin
            wa_reg <= haddr_i[7:0];
         end
      end
   end

   // RQ23 level 0 writes refused per field; RQ14 sensitivity
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pri_reg[0] <= `NPIC_PRI_RST;
         pri_reg[1] <= `NPIC_PRI_RST;
         pri_reg[2] <= `NPIC_PRI_RST;
         pri_reg[3] <= `NPIC_PRI_RST;
         sens_reg   <= 6'h00;
         psel_reg   <= PW'(`NPIC_PSEL_RST);
      end else if (ce_i && wr_ph_reg) begin
         if (wa_reg == `NPIC_OFS_PRI0) begin
            pri_reg[0] <= npic_pkg::npic_pri_wr(pri_reg[0], hwdata_i[7:0]);
         end else if (wa_reg == `NPIC_OFS_PRI1) begin
            pri_reg[1] <= npic_pkg::npic_pri_wr(pri_reg[1], hwdata_i[7:0]);
         end else if (wa_reg == `NPIC_OFS_PRI2) begin
            pri_reg[2] <= npic_pkg::npic_pri_wr(pri_reg[2], hwdata_i[7:0]);
         end else if (wa_reg == `NPIC_OFS_PRI3) begin
            pri_reg[3] <= npic_pkg::npic_pri_wr(pri_reg[3], hwdata_i[7:0]) | `NPIC_PRI3_RO;
         end else if (wa_reg == `NPIC_OFS_SENS) begin
            sens_reg <= hwdata_i[5:0];
         end else if (wa_reg == `NPIC_OFS_PSEL) begin
            psel_reg <= hwdata_i[PW-1:0];
         end
      end
   end

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_b_i || !ce_i);

   sequence s_enter;
      take;
   endsequence

   sequence s_stack;
      !stk_we_o ##1 stk_we_o [*5] ##1 (!stk_we_o && pc_load_o);
   endsequence

   a_entry_bound: assert property ($rose(stk_we_o) |-> $past(instr_end_i, 2)) // RQ1
      else $error("stacking began without an instruction end");

   a_stack_five: assert property (s_enter |=> s_stack) // RQ2
      else $error("entry did not push five bytes then load the vector");

   a_level_load: assert property (s_enter and !trap_pend_reg
                                  |-> ##7 cc_pri_reg == $past(arb_if.pri_code, 7)) // RQ3
      else $error("priority bits not loaded from the vector priority");

   a_vector_addr: assert property (s_enter and !trap_pend_reg |-> ##7 (pc_load_o
      && vector_o == 16'(`NPIC_VEC_BASE - {11'h000, $past(arb_if.idx, 7), 1'b0}))) // RQ4
      else $error("wrong vector address");

   a_return_from_interrupt_pop: assert property (return_from_interrupt_i && state_reg == npic_pkg::ST_IDLE
      |=> cc_pri_reg == {$past(cc_data_i[`NPIC_CC_HI]), $past(cc_data_i[`NPIC_CC_LO])}) // RQ5
      else $error("return did not restore the priority bits");

   a_nmi_level3: assert property (s_enter and trap_pend_reg
      |-> ##7 (cc_pri_reg == `NPIC_LVL3 && vector_o == `NPIC_VEC_TRAP)) // RQ9
      else $error("trap entry not at level 3");

   a_reset_first: assert property (state_reg == npic_pkg::ST_RESET
      |=> pc_load_o && vector_o == `NPIC_VEC_RESET && cc_pri_reg == `NPIC_LVL3) // RQ12
      else $error("reset vector not loaded at level 3");

   a_mask_above: assert property (s_enter and !trap_pend_reg
      |-> npic_pkg::npic_rank(arb_if.pri_code) > npic_pkg::npic_rank(cc_pri_reg)) // RQ13
      else $error("request taken at or below the current level");

   a_halt_first: assert property (s_enter and !trap_pend_reg and halt_exit_reg
      |-> HALT_CAP[arb_if.idx]) // RQ20
      else $error("first service after Halt not Halt-capable");

   a_clr_drops: assert property (|periph_clr_i |=> (pend_reg & $past(periph_clr_i)) == 13'h0000) // RQ18
      else $error("clear sequence did not drop the request");
endmodule : npic_top
